/* File: lais_pkg.sv */
// Constants, field layout and carrier types of the line alarm status block
package lais_pkg;

  // Channel count and address stride between channel copies
  localparam int NUM_CH = 2;
  localparam logic [7:0] CH_STRIDE = 8'h20;

  // Register offsets of channel 0; channel 1 adds CH_STRIDE
  localparam logic [7:0] OFF_MASK_FIRST = 8'h13;
  localparam logic [7:0] OFF_MASK_SECOND = 8'h14;
  localparam logic [7:0] OFF_EDGE_SEL = 8'h15;
  localparam logic [7:0] OFF_COND_LIVE = 8'h16;
  localparam logic [7:0] OFF_LOOP_LIVE = 8'h17;
  localparam logic [7:0] OFF_LATCH_FIRST = 8'h18;
  localparam logic [7:0] OFF_LATCH_SECOND = 8'h19;

  // Reset values
  localparam logic [7:0] MASK_SECOND_RST = 8'hFF;
  localparam logic [4:0] MASK_FIRST_RST = 5'h1F;
  localparam logic [2:0] MASK_FIRST_RSVD = 3'h7;
  localparam logic [4:0] EDGE_SEL_RST = 5'h00;
  localparam logic [4:0] COND_LIVE_RST = 5'h00;
  localparam logic [4:0] LATCH_FIRST_RST = 5'h00;
  localparam logic [7:0] LATCH_SECOND_RST = 8'h00;
  localparam logic [7:0] RD_DATA_IDLE = 8'h00;

  // Field positions of the live condition register
  localparam int SEQ_LOCK_BIT = 4;
  localparam int TXCLK_LOSS_BIT = 3;
  localparam int DRIVER_FAULT_BIT = 2;
  localparam int ALARM_IND_BIT = 1;
  localparam int SIGNAL_LOSS_BIT = 0;
  // Field position of the loopback state register
  localparam int REMOTE_LOOP_BIT = 5;

  // Field positions of the second mask register
  localparam int WAVE_OVERFLOW_BIT = 7;
  localparam int JITTER_BUF_OVER_BIT = 6;
  localparam int JITTER_BUF_UNDER_BIT = 5;
  localparam int SEQUENCE_ERROR_BIT = 4;
  localparam int EXCESS_ZEROS_BIT = 3;
  localparam int CODE_VIOLATION_BIT = 2;
  localparam int SECOND_TICK_BIT = 1;
  localparam int COUNTER_OVERFLOW_BIT = 0;

  // Transmit clock idle limit, in master clock cycles
  localparam logic [6:0] TXCLK_LOSS_CYCLES = 7'h46;
  localparam logic [6:0] IDLE_CNT_RST = 7'h00;

  // Live line conditions from the channel detectors
  typedef struct packed {
    logic seq_lock;
    logic driver_fault;
    logic alarm_ind;
    logic signal_loss;
    logic remote_loop;
  } lais_cond_t;

  // One-cycle event pulses of the second mask group, bit 7 first
  typedef struct packed {
    logic wave_overflow;
    logic jitter_buf_over;
    logic jitter_buf_under;
    logic sequence_error;
    logic excess_zeros;
    logic code_violation;
    logic second_tick;
    logic counter_overflow;
  } lais_evt_t;

  // Host register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lais_bus_t;

endpackage

/* File: lais_core.sv */
// Per-channel line status, edge select, masks and latched events
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
// Function
// - Second mask bit 7 masks waveform overflow interrupt when 1; resets 1.
// - Second mask bits 6,5 mask jitter buffer over/underflow; reset 1.
// - Second mask bit 4 masks sequence error interrupt; resets 1.
// - Second mask bit 3 masks excess zeros interrupt; resets 1.
// - Second mask bit 2 masks code violation interrupt; resets 1.
// - Second mask bits 1,0 mask second tick and counter overflow; reset 1.
// - Edge select bit 4: sequence lock rise only, or any change.
// - Edge select bit 3: transmit clock loss rise only, or any change.
// - Edge select bit 2: driver fault rise only, or any change.
// - Edge select bit 1: alarm indication rise only, or any change.
// - Edge select bit 0: signal loss rise only, or any change.
// - Status change interrupts only while mask bit 0; edge per select.
// - Live bit 4 shows pseudo-random sequence lock; resets 0.
// - Live bit 3 set after over 70 cycles without transmit clock toggle.
// - Live bit 2 shows line driver short circuit.
// - Live bit 1 shows alarm indication signal in receive path.
// - Live bit 0 shows loss of signal on receive pair.
// - Loopback register bit 5 shows remote loopback; other bits reserved.
// - Live registers read-only, unlatched, one copy per channel.
// - Latched event registers clear on read, dropping the request.
module lais_core (
  input wire logic clk_in, // Master clock
  input wire logic rst_n_in, // Asynchronous reset, active low
  input wire lais_pkg::lais_bus_t host_in, // Host register request
  output logic [7:0] rd_data_out, // Read data, cycle after read
  input wire lais_pkg::lais_cond_t [1:0] cond_in, // Detector levels
  input wire lais_pkg::lais_evt_t [1:0] evt_in, // Event pulses
  input wire logic [1:0] transmit_clock_pin_in, // Transmit clock pins
  output logic [1:0] irq_out // Interrupt request per channel
);

  // Address match for one register of one channel
  function automatic logic lais_hit(input logic [7:0] addr,
                                    input logic ch,
                                    input logic [7:0] off);
    logic [7:0] target;
    target = ch ? 8'(off + lais_pkg::CH_STRIDE) : off;
    return addr == target;
  endfunction

  // Qualifying transition: rise always, fall too where selected
  function automatic logic [4:0] lais_edge(input logic [4:0] now_v,
                                           input logic [4:0] old_v,
                                           input logic [4:0] sel);
    return (now_v & ~old_v) | (sel & (now_v ^ old_v));
  endfunction

  logic rst_meta_reg;
  logic rst_sync_reg;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  logic [7:0] mask_second_reg [2];
  logic [7:0] mask_second_next [2];
  logic [4:0] mask_first_reg [2];
  logic [4:0] mask_first_next [2];
  logic [4:0] edge_sel_reg [2];
  logic [4:0] edge_sel_next [2];

  // Host writes to the control registers; status registers ignore writes
  always_comb
  begin
    for (int c = 0; c < lais_pkg::NUM_CH; c++)
    begin
      mask_second_next[c] = mask_second_reg[c];
      mask_first_next[c] = mask_first_reg[c];
      edge_sel_next[c] = edge_sel_reg[c];
      if (host_in.wr)
      begin
        if (lais_hit(host_in.addr, 1'(c), lais_pkg::OFF_MASK_SECOND))
          mask_second_next[c] = host_in.wdata;
        else if (lais_hit(host_in.addr, 1'(c), lais_pkg::OFF_MASK_FIRST))
          mask_first_next[c] = host_in.wdata[4:0];
        else if (lais_hit(host_in.addr, 1'(c), lais_pkg::OFF_EDGE_SEL))
          edge_sel_next[c] = host_in.wdata[4:0];
      end
    end
  end

  // Control registers; masks come up masked, edges rising-only
  always_ff @(posedge clk_in or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      for (int c = 0; c < lais_pkg::NUM_CH; c++)
      begin
        mask_second_reg[c] <= lais_pkg::MASK_SECOND_RST;
        mask_first_reg[c] <= lais_pkg::MASK_FIRST_RST;
        edge_sel_reg[c] <= lais_pkg::EDGE_SEL_RST;
      end
    end
    else
    begin
      mask_second_reg <= mask_second_next;
      mask_first_reg <= mask_first_next;
      edge_sel_reg <= edge_sel_next;
    end
  end

  logic [1:0] pin_prev_reg;
  logic [1:0] pin_prev_next;
  logic [6:0] idle_cnt_reg [2];
  logic [6:0] idle_cnt_next [2];

  // Transmit clock watchdog; saturates one past the limit
  always_comb
  begin
    pin_prev_next = transmit_clock_pin_in;
    for (int c = 0; c < lais_pkg::NUM_CH; c++)
    begin
      if (transmit_clock_pin_in[c] != pin_prev_reg[c])
        idle_cnt_next[c] = lais_pkg::IDLE_CNT_RST;
      else if (idle_cnt_reg[c] > lais_pkg::TXCLK_LOSS_CYCLES)
        idle_cnt_next[c] = idle_cnt_reg[c];
      else
        idle_cnt_next[c] = 7'(idle_cnt_reg[c] + 7'h01);
    end
  end

  // Watchdog registers
  always_ff @(posedge clk_in or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      pin_prev_reg <= 2'h0;
      for (int c = 0; c < lais_pkg::NUM_CH; c++)
        idle_cnt_reg[c] <= lais_pkg::IDLE_CNT_RST;
    end
    else
    begin
      pin_prev_reg <= pin_prev_next;
      idle_cnt_reg <= idle_cnt_next;
    end
  end

  logic [4:0] cond_live_reg [2];
  logic [4:0] cond_live_next [2];
  logic [1:0] loop_live_reg;
  logic [1:0] loop_live_next;
  logic [4:0] latch_first_reg [2];
  logic [4:0] latch_first_next [2];
  logic [7:0] latch_second_reg [2];
  logic [7:0] latch_second_next [2];
  logic [1:0] irq_reg;
  logic [1:0] irq_next;
  logic [4:0] cond_evt;
  logic rd_first;
  logic rd_second;

  // Live status, event latching and request; set beats read-clear
  always_comb
  begin
    irq_next = 2'h0;
    cond_evt = 5'h00;
    rd_first = 1'b0;
    rd_second = 1'b0;
    for (int c = 0; c < lais_pkg::NUM_CH; c++)
    begin
      cond_live_next[c][lais_pkg::SEQ_LOCK_BIT] = cond_in[c].seq_lock;
      cond_live_next[c][lais_pkg::DRIVER_FAULT_BIT] = cond_in[c].driver_fault;
      cond_live_next[c][lais_pkg::ALARM_IND_BIT] = cond_in[c].alarm_ind;
      cond_live_next[c][lais_pkg::SIGNAL_LOSS_BIT] = cond_in[c].signal_loss;
      // loss once idle for more than the limit
      cond_live_next[c][lais_pkg::TXCLK_LOSS_BIT] =
        idle_cnt_next[c] > lais_pkg::TXCLK_LOSS_CYCLES;
      loop_live_next[c] = cond_in[c].remote_loop;
      cond_evt = lais_edge(cond_live_next[c], cond_live_reg[c],
                           edge_sel_reg[c]);
      rd_first = host_in.rd &&
        lais_hit(host_in.addr, 1'(c), lais_pkg::OFF_LATCH_FIRST);
      rd_second = host_in.rd &&
        lais_hit(host_in.addr, 1'(c), lais_pkg::OFF_LATCH_SECOND);
      // read clears, a same-cycle event survives
      latch_first_next[c] =
        (rd_first ? lais_pkg::LATCH_FIRST_RST : latch_first_reg[c]) |
        cond_evt;
      latch_second_next[c] =
        (rd_second ? lais_pkg::LATCH_SECOND_RST : latch_second_reg[c]) |
        evt_in[c];
      // request gated by mask bits at 0
      irq_next[c] = |(latch_first_next[c] & ~mask_first_next[c]) ||
                    |(latch_second_next[c] & ~mask_second_next[c]);
    end
  end

  // Status and request registers
  always_ff @(posedge clk_in or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      loop_live_reg <= 2'h0;
      irq_reg <= 2'h0;
      for (int c = 0; c < lais_pkg::NUM_CH; c++)
      begin
        cond_live_reg[c] <= lais_pkg::COND_LIVE_RST;
        latch_first_reg[c] <= lais_pkg::LATCH_FIRST_RST;
        latch_second_reg[c] <= lais_pkg::LATCH_SECOND_RST;
      end
    end
    else
    begin
      cond_live_reg <= cond_live_next;
      loop_live_reg <= loop_live_next;
      latch_first_reg <= latch_first_next;
      latch_second_reg <= latch_second_next;
      irq_reg <= irq_next;
    end
  end

  logic [7:0] rd_data_reg;
  logic [7:0] rd_data_next;

  // Read mux; data stands only in the cycle after the strobe
  always_comb
  begin
    rd_data_next = lais_pkg::RD_DATA_IDLE;
    if (host_in.rd)
    begin
      for (int c = 0; c < lais_pkg::NUM_CH; c++)
      begin
        if (lais_hit(host_in.addr, 1'(c), lais_pkg::OFF_MASK_SECOND))
          rd_data_next = mask_second_reg[c];
        else if (lais_hit(host_in.addr, 1'(c), lais_pkg::OFF_MASK_FIRST))
          rd_data_next = {lais_pkg::MASK_FIRST_RSVD, mask_first_reg[c]};
        else if (lais_hit(host_in.addr, 1'(c), lais_pkg::OFF_EDGE_SEL))
          rd_data_next = {3'h0, edge_sel_reg[c]};
        else if (lais_hit(host_in.addr, 1'(c), lais_pkg::OFF_COND_LIVE))
          rd_data_next = {3'h0, cond_live_reg[c]};
        else if (lais_hit(host_in.addr, 1'(c), lais_pkg::OFF_LOOP_LIVE))
          rd_data_next = {2'h0, loop_live_reg[c], 5'h00};
        else if (lais_hit(host_in.addr, 1'(c), lais_pkg::OFF_LATCH_FIRST))
          rd_data_next = {3'h0, latch_first_reg[c]};
        else if (lais_hit(host_in.addr, 1'(c), lais_pkg::OFF_LATCH_SECOND))
          rd_data_next = latch_second_reg[c];
      end
    end
  end

  // Read data register
  always_ff @(posedge clk_in or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
      rd_data_reg <= lais_pkg::RD_DATA_IDLE;
    else
      rd_data_reg <= rd_data_next;
  end

  // Outputs straight from flops
  assign rd_data_out = rd_data_reg;
  assign irq_out = irq_reg;

endmodule
`default_nettype wire

/* File: lais_monitor.sv */
// Checker of readback, live status and request timing
`timescale 1ns/1ns
`default_nettype none
module lais_monitor (
  input wire logic clk_in, // Master clock
  input wire logic rst_n_in, // Reset, active low
  input wire lais_pkg::lais_bus_t host_in, // Host request
  input wire logic [7:0] rd_data_out, // Read data
  input wire lais_pkg::lais_cond_t [1:0] cond_in, // Conditions
  input wire lais_pkg::lais_evt_t [1:0] evt_in, // Event pulses
  input wire logic [1:0] transmit_clock_pin_in, // Transmit clocks
  input wire logic [1:0] irq_out // Requests
);
  logic [7:0] m2_reg;
  logic [4:0] m1_reg;
  logic [4:0] es_reg;
  logic [6:0] idle_reg;
  logic pin_reg;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Shadows of channel 0 writes; idle run of pin 0 saturates
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      m2_reg <= 8'hFF;
      m1_reg <= 5'h1F;
      es_reg <= 5'h00;
      idle_reg <= 7'h00;
      pin_reg <= 1'h0;
    end
    else
    begin
      pin_reg <= transmit_clock_pin_in[0];
      if (transmit_clock_pin_in[0] != pin_reg)
        idle_reg <= 7'h00;
      else
        idle_reg <= idle_reg + {6'h00, ~&idle_reg};
      if (host_in.wr && host_in.addr == 8'h14)
        m2_reg <= host_in.wdata;
      if (host_in.wr && host_in.addr == 8'h13)
        m1_reg <= host_in.wdata[4:0];
      if (host_in.wr && host_in.addr == 8'h15)
        es_reg <= host_in.wdata[4:0];
    end
  end
  // Read data and live status relations
  a_rd_idle_zero: assert property (
    !$past(host_in.rd) |-> rd_data_out == 8'h00)
    else $error("read data outside answer cycle");
  a_live_read: assert property (
    host_in.rd && host_in.addr == 8'h16 && $stable(cond_in)
    |=> rd_data_out[2:0] == $past(cond_in[0][3:1])
    && rd_data_out[7:4] == {3'h0, $past(cond_in[0].seq_lock)})
    else $error("live condition read wrong");
  a_loop_read: assert property (
    host_in.rd && host_in.addr == 8'h17 && $stable(cond_in[0])
    |=> rd_data_out == {2'h0, $past(cond_in[0].remote_loop), 5'h00})
    else $error("loopback read wrong");
  a_mask_readback: assert property (
    host_in.rd && host_in.addr == 8'h14 |=> rd_data_out == m2_reg)
    else $error("second mask read wrong");
  a_edge_readback: assert property (
    host_in.rd && host_in.addr == 8'h15
    |=> rd_data_out == {3'h0, es_reg})
    else $error("edge select read wrong");
  a_all_masked: assert property (
    m1_reg == 5'h1F && m2_reg == 8'hFF |-> !irq_out[0])
    else $error("request while all masked");
  a_evt_irq: assert property (
    |(evt_in[0] & ~m2_reg) && !host_in.wr |=> irq_out[0])
    else $error("unmasked event gave no request");
  a_los_rise: assert property (
    $rose(cond_in[0].signal_loss) && !m1_reg[0] && !host_in.wr
    |=> irq_out[0])
    else $error("signal loss rise gave no request");
  a_txclk_loss: assert property (
    host_in.rd && host_in.addr == 8'h16
    && (idle_reg >= 7'h4C || (idle_reg > 7'h02 && idle_reg < 7'h40))
    |=> rd_data_out[3] == ($past(idle_reg) >= 7'h4C))
    else $error("transmit clock loss flag wrong");
endmodule
`default_nettype wire

/* File: lais_host_model.sv */
// Host processor model driving the register port
`timescale 1ns/1ns
`default_nettype none
module lais_host_model (
  input wire logic clk_in, // Master clock
  input wire logic [7:0] rd_data_in, // Read data from block
  output var lais_pkg::lais_bus_t bus_out // Register request
);
  initial bus_out = '0;
  // One-cycle write; released lines carry scrambled values
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    bus_out <= {2'b10, a, d};
    @(posedge clk_in);
    bus_out <= {2'b00, ~a, ~d};
  endtask
  // One-cycle read; data taken in the following cycle only
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    bus_out <= {2'b01, a, 8'h00};
    @(posedge clk_in);
    bus_out <= {2'b00, ~a, 8'hFF};
    @(posedge clk_in);
    d = rd_data_in;
  endtask
endmodule
`default_nettype wire

/* File: test_line_alarm_interrupt_status.sv */
// Self-checking bench of the line alarm status block
`timescale 1ns/1ns
`default_nettype none
module test_line_alarm_interrupt_status;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  lais_pkg::lais_bus_t host_bus;
  logic [7:0] rd_data;
  lais_pkg::lais_cond_t [1:0] cond = '0;
  lais_pkg::lais_evt_t [1:0] evt = '0;
  logic [1:0] pin = 2'h0;
  logic [1:0] run = 2'h3;
  logic [1:0] irq;
  logic [7:0] v;
  logic [7:0] m;
  logic [7:0] b;
  int fail_count = 0;
  int checks_done = 0;
  // Clock; transmit clocks toggle while running
  always #2 clk_in = ~clk_in;
  always @(posedge clk_in) pin <= pin ^ run;
  lais_core lais_core_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .host_in(host_bus), .rd_data_out(rd_data), .cond_in(cond),
    .evt_in(evt), .transmit_clock_pin_in(pin), .irq_out(irq));
  lais_host_model lais_host_model_inst (.clk_in(clk_in),
    .rd_data_in(rd_data), .bus_out(host_bus));
  // Expected live condition byte
  function automatic logic [7:0] live(input lais_pkg::lais_cond_t c);
    return {3'h0, c.seq_lock, 1'b0, c.driver_fault, c.alarm_ind,
      c.signal_loss};
  endfunction
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e,
    input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd_chk(input string n, input logic [7:0] a,
    input logic [7:0] e);
    logic [7:0] d;
    lais_host_model_inst.rd_reg(a, d);
    chk(n, e, d);
  endtask
  task automatic irq_is(input logic e);
    chk("irq0", {7'h00, e}, {7'h00, irq[0]});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    lais_host_model_inst.wr_reg(a, d);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // Watchdog cuts a hang short
  initial
  begin
    tick(20000);
    fail_count++;
    give_verdict;
  end
  // Main sequence
  initial
  begin
    v = 8'($urandom(4));
    tick(12);
    rst_n_in <= 1'b1;
    tick(3);
    for (int c = 0; c < 2; c++)
    begin
      b = c[0] ? 8'h20 : 8'h00;
      rd_chk("mask2", 8'h14 + b, 8'hFF);
      rd_chk("edge", 8'h15 + b, 8'h00);
      rd_chk("live", 8'h16 + b, 8'h00);
      rd_chk("unmapped", 8'h05 + b, 8'h00);
      repeat (6)
      begin
        v = 8'($urandom);
        wr(8'h14 + b, v);
        wr(8'h15 + b, v);
        wr(8'h16 + b, v);
        rd_chk("mask2", 8'h14 + b, v);
        rd_chk("edge", 8'h15 + b, {3'h0, v[4:0]});
        rd_chk("live ro", 8'h16 + b, 8'h00);
      end
    end
    $display("test registers done");
    repeat (8)
    begin
      cond <= 10'($urandom);
      tick(2);
      rd_chk("live0", 8'h16, live(cond[0]));
      rd_chk("live1", 8'h36, live(cond[1]));
      rd_chk("loop1", 8'h37, {2'h0, cond[1].remote_loop, 5'h00});
    end
    cond <= '0;
    wr(8'h14, 8'hFF);
    wr(8'h13, 8'h1F);
    tick(2);
    // Drain whatever the random levels latched, then both must read empty
    lais_host_model_inst.rd_reg(8'h18, m);
    lais_host_model_inst.rd_reg(8'h19, m);
    rd_chk("clear", 8'h18, 8'h00);
    rd_chk("clear2", 8'h19, 8'h00);
    $display("test live done");
    for (int k = 0; k < 5; k++)
    begin
      if (k != 3)
      begin
        wr(8'h13, ~(8'h01 << k));
        wr(8'h15, 8'h00);
        cond[0][k + int'(k < 3)] <= 1'b1;
        tick(2);
        irq_is(1'b1);
        rd_chk("latch", 8'h18, 8'h01 << k);
        irq_is(1'b0);
        cond[0][k + int'(k < 3)] <= 1'b0;
        tick(2);
        irq_is(1'b0);
        wr(8'h15, 8'h01 << k);
        cond[0][k + int'(k < 3)] <= 1'b1;
        tick(2);
        rd_chk("latch", 8'h18, 8'h01 << k);
        cond[0][k + int'(k < 3)] <= 1'b0;
        tick(2);
        irq_is(1'b1);
        rd_chk("latch", 8'h18, 8'h01 << k);
      end
    end
    $display("test edges done");
    wr(8'h13, 8'hF7);
    wr(8'h15, 8'h08);
    run <= 2'h0;
    tick(80);
    rd_chk("txloss", 8'h16, 8'h08);
    rd_chk("txloss1", 8'h36, 8'h08);
    rd_chk("latch", 8'h18, 8'h08);
    run <= 2'h3;
    tick(4);
    irq_is(1'b1);
    rd_chk("txok", 8'h16, 8'h00);
    rd_chk("latch", 8'h18, 8'h08);
    wr(8'h13, 8'h1F);
    $display("test txclk done");
    for (int i = 0; i < 12; i++)
    begin
      m = i ? 8'($urandom) : 8'hFF;
      v = i ? 8'($urandom) : 8'hFF;
      wr(8'h14, m);
      wr(8'h34, m);
      evt <= {v, v};
      tick(1);
      evt <= '0;
      tick(1);
      irq_is(|(v & ~m));
      chk("irq1", {7'h00, |(v & ~m)}, {7'h00, irq[1]});
      rd_chk("latch2", 8'h19, v);
      irq_is(1'b0);
      rd_chk("latch2b", 8'h39, v);
    end
    $display("test events done");
    give_verdict;
  end
endmodule
bind lais_core lais_monitor lais_monitor_inst (.clk_in(clk_in),
  .rst_n_in(rst_n_in), .host_in(host_in), .rd_data_out(rd_data_out),
  .cond_in(cond_in), .evt_in(evt_in),
  .transmit_clock_pin_in(transmit_clock_pin_in), .irq_out(irq_out));
`default_nettype wire
